// ### epaper_serial_host_port.sv
/*
 * host serial port of a small display module: select gating, command/data
 * qualifier, 3/4-line strap, read shift-out and busy output.
 * assumes the host serial clock is well below mclk/4 (bench: 400 ns period writing, 500 ns reading);
 * all pins are sampled by mclk through two flops.
 */
`timescale 1ns/1ps
module epaper_serial_host_port
    import epd_port_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       reset_n_input,
    input  wire logic       bus_width_strap,
    input  wire logic       sel_n,
    input  wire logic       sclk,
    input  wire logic       sdata_in,
    output logic            sdata_out,
    output logic            sdata_oe,
    input  wire logic       dc_sel,
    input  wire logic       waveform_active,
    input  wire logic       sensor_active,
    input  wire logic       read_request,
    input  wire logic [7:0] read_byte,
    output logic            read_byte_take,
    output logic [7:0]      rx_byte,
    output logic            rx_is_data,
    output logic            rx_valid,
    output logic            three_line_mode,
    output logic            busy
);
    import epd_port_pkg::*;

    logic        sel_n_s;
    logic        sel_fall;
    logic        sel_rise;
    logic        sclk_rise;
    logic        sclk_fall;
    logic        sdin_s;
    logic        dc_meta_ff;
    logic        dc_s_ff;
    logic        strap_meta_ff;
    logic        strap_s_ff;
    logic        rstn_meta_ff;
    logic        rstn_s_ff;
    logic        srst;
    link_state_e state_ff;
    logic [3:0]  bit_cnt_ff;
    logic [8:0]  shift_ff;
    logic        mode3_ff;
    logic [7:0]  tx_ff;
    logic [2:0]  tx_cnt_ff;
    logic [5:0]  busy_cnt_ff;
    logic        busy_ff;
    logic        rx_valid_ff;
    logic [7:0]  rx_byte_ff;
    logic        rx_is_data_ff;
    logic        take_ff;
    logic [3:0]  last_idx;
    logic        word_done;

    // =====================================================================
    // pin synchronisers
    // =====================================================================
    epd_edge_sync #(.INIT(1'b1)) u_sel (
        .clk(mclk), .rst(rst), .din(sel_n), .level(sel_n_s), .rise(sel_rise), .fall(sel_fall)
    );
    epd_edge_sync #(.INIT(1'b0)) u_sclk (
        .clk(mclk), .rst(rst), .din(sclk), .level(), .rise(sclk_rise), .fall(sclk_fall)
    );
    epd_edge_sync #(.INIT(1'b0)) u_sdin (
        .clk(mclk), .rst(rst), .din(sdata_in), .level(sdin_s), .rise(), .fall()
    );

    // level pins: qualifier, strap, module reset
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            dc_meta_ff    <= 1'b0;
            dc_s_ff       <= 1'b0;
            strap_meta_ff <= 1'b0;
            strap_s_ff    <= 1'b0;
            rstn_meta_ff  <= 1'b0;
            rstn_s_ff     <= 1'b0;
        end else begin
            dc_meta_ff    <= dc_sel;
            dc_s_ff       <= dc_meta_ff;
            strap_meta_ff <= bus_width_strap;
            strap_s_ff    <= strap_meta_ff;
            rstn_meta_ff  <= reset_n_input;
            rstn_s_ff     <= rstn_meta_ff;
        end
    end

    assign srst = ~rstn_s_ff;

    // strap is caught only while idle with select high, or under module reset, so a word never changes length midway
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            mode3_ff <= 1'b0;
        end else if (srst || (state_ff == LINK_IDLE && sel_n_s)) begin
            mode3_ff <= (strap_s_ff != STRAP_4LINE);
        end
    end

    assign last_idx  = mode3_ff ? WORD3_LAST : WORD4_LAST;
    assign word_done = (bit_cnt_ff == last_idx);

    // =====================================================================
    // receive state machine and shifter
    // =====================================================================
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_ff   <= LINK_IDLE;
            bit_cnt_ff <= 4'h0;
            shift_ff   <= 9'h000;
        end else if (srst || sel_n_s) begin
            // partial words are dropped when select rises
            state_ff   <= LINK_IDLE;
            bit_cnt_ff <= 4'h0;
            shift_ff   <= 9'h000;
        end else begin
            unique case (state_ff)
                LINK_IDLE: begin
                    state_ff <= LINK_SHIFT;
                end
                LINK_SHIFT: begin
                    if (sclk_rise) begin
                        shift_ff <= {shift_ff[7:0], sdin_s};  // msb first
                        if (word_done) begin
                            bit_cnt_ff <= 4'h0;
                            if (read_request) begin
                                state_ff <= LINK_READ;
                            end
                        end else begin
                            bit_cnt_ff <= bit_cnt_ff + 4'h1;
                        end
                    end
                end
                LINK_READ: begin
                    state_ff <= LINK_READ;  // held until select rises
                end
                default: begin
                    state_ff <= LINK_IDLE;
                end
            endcase
        end
    end

    // completed word: qualifier from pin in 4-line, from leading bit in 3-line
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rx_valid_ff   <= 1'b0;
            rx_byte_ff    <= 8'h00;
            rx_is_data_ff <= 1'b0;
        end else begin
            rx_valid_ff <= 1'b0;
            if (!srst && !sel_n_s && state_ff == LINK_SHIFT && sclk_rise && word_done) begin
                rx_valid_ff <= 1'b1;
                rx_byte_ff  <= {shift_ff[6:0], sdin_s};
                if (mode3_ff) begin
                    rx_is_data_ff <= (shift_ff[7] == QUAL_DATA);
                end else begin
                    rx_is_data_ff <= (dc_s_ff == QUAL_DATA);
                end
            end
        end
    end

    // =====================================================================
    // read shift-out on falling edges
    // =====================================================================
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tx_ff     <= 8'h00;
            tx_cnt_ff <= 3'h0;
            take_ff   <= 1'b0;
        end else begin
            take_ff <= 1'b0;
            if (srst || sel_n_s || state_ff != LINK_READ) begin
                tx_cnt_ff <= 3'h0;
                tx_ff     <= read_byte;
            end else if (sclk_fall) begin
                if (tx_cnt_ff == 3'h0) begin
                    tx_ff   <= read_byte;  // msb goes out on this edge
                    take_ff <= 1'b1;
                end else begin
                    tx_ff <= {tx_ff[6:0], 1'b0};
                end
                tx_cnt_ff <= tx_cnt_ff + 3'h1;
            end
        end
    end

    assign sdata_out      = tx_ff[7];
    assign sdata_oe       = (state_ff == LINK_READ) && !sel_n_s;
    assign read_byte_take = take_ff;

    // =====================================================================
    // busy: held while a cause is active and a short stretch after
    // =====================================================================
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            busy_cnt_ff <= 6'h00;
            busy_ff     <= 1'b0;
        end else if (srst) begin
            busy_cnt_ff <= 6'h00;
            busy_ff     <= 1'b0;
        end else if (waveform_active || sensor_active) begin
            busy_cnt_ff <= BUSY_STRETCH_LD;
            busy_ff     <= 1'b1;
        end else if (busy_cnt_ff != 6'h00) begin
            busy_cnt_ff <= busy_cnt_ff - 6'h01;
            busy_ff     <= (busy_cnt_ff != 6'h01);
        end
    end

    assign busy            = busy_ff;  // host must hold off while high
    assign rx_byte         = rx_byte_ff;
    assign rx_is_data      = rx_is_data_ff;
    assign rx_valid        = rx_valid_ff;
    assign three_line_mode = mode3_ff;

    // =====================================================================
    // checks
    // =====================================================================
    chk_sel_gates_rx: assert property (@(posedge mclk) disable iff (rst)
        rx_valid |-> !$past(sel_n_s))
        else $error("word accepted while select high");
    chk_qual_4line: assert property (@(posedge mclk) disable iff (rst)
        rx_valid && !mode3_ff |-> rx_is_data == $past(dc_s_ff))
        else $error("4-line qualifier mismatch");
    chk_qual_3line: assert property (@(posedge mclk) disable iff (rst)
        rx_valid && mode3_ff |-> rx_is_data == $past(shift_ff[7]))
        else $error("3-line qualifier not from leading bit");
    chk_reset_idle: assert property (@(posedge mclk) disable iff (rst)
        srst |=> state_ff == LINK_IDLE && !busy && !rx_valid)
        else $error("logic active under module reset");
    chk_busy_cause: assert property (@(posedge mclk) disable iff (rst)
        (waveform_active || sensor_active) && !srst |=> busy)
        else $error("busy not raised");
    chk_busy_drop: assert property (@(posedge mclk) disable iff (rst)
        $fell(busy) && !$past(srst) |-> $past(busy_cnt_ff) == 6'h01)
        else $error("busy dropped early");
    chk_abort_clear: assert property (@(posedge mclk) disable iff (rst)
        sel_rise |=> bit_cnt_ff == 4'h0 && state_ff == LINK_IDLE)
        else $error("partial word kept after select rise");
    chk_bit_bound: assert property (@(posedge mclk) disable iff (rst)
        bit_cnt_ff <= last_idx)
        else $error("bit count past word end");
    // while driving, the read line may only move after a detected falling edge
    chk_read_drive: assert property (@(posedge mclk) disable iff (rst)
        sdata_oe && $past(sdata_oe) && !$past(sclk_fall) |-> $stable(sdata_out))
        else $error("read data moved off a falling edge");

    cov_word4: cover property (@(posedge mclk) rx_valid && !mode3_ff);
    cov_word3: cover property (@(posedge mclk) rx_valid && mode3_ff && rx_is_data);
    cov_read: cover property (@(posedge mclk) read_byte_take);
    cov_abort: cover property (@(posedge mclk) sel_rise && bit_cnt_ff != 4'h0);
endmodule

// ### epd_edge_sync.sv
/*
 * two-flop synchroniser with rise and fall detect taken from the second flop.
 * assumes the input is asynchronous to clk; reset value is a parameter.
 */
`timescale 1ns/1ps
module epd_edge_sync #(
    parameter logic INIT = 1'b0
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic din,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic meta_ff;
    logic sync_ff;
    logic last_ff;

    // =====================================================================
    // synchroniser: the first flop feeds only the second
    // =====================================================================
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_ff <= INIT;
            sync_ff <= INIT;
            last_ff <= INIT;
        end else begin
            meta_ff <= din;
            sync_ff <= meta_ff;
            last_ff <= sync_ff;
        end
    end

    assign level = sync_ff;
    assign rise  = sync_ff & ~last_ff;
    assign fall  = ~sync_ff & last_ff;
endmodule

// ### epd_port_pkg.sv
/*
 * constants shared by the display host serial port: timing, word sizes, states.
 * assumes a single 20 MHz system clock; the serial clock is sampled, not used as a clock.
 */
package epd_port_pkg;
    // =====================================================================
    // system clock and timing
    // =====================================================================
    localparam int CLK_HZ          = 20_000_000;
    localparam int BUSY_STRETCH_NS = 1000;  // least time busy stays up after a busy cause
    localparam int BUSY_STRETCH_CYC =
        ((BUSY_STRETCH_NS * (CLK_HZ / 1_000_000)) + 999) / 1000;
    localparam logic [5:0] BUSY_STRETCH_LD = 6'(BUSY_STRETCH_CYC);

    // =====================================================================
    // word layout
    // =====================================================================
    localparam int         BYTE_BITS   = 8;
    localparam logic [3:0] WORD4_LAST  = 4'h7;  // last bit index, 4-line word of 8
    localparam logic [3:0] WORD3_LAST  = 4'h8;  // last bit index, 3-line word of 9
    localparam logic       QUAL_CMD    = 1'b0;
    localparam logic       QUAL_DATA   = 1'b1;
    localparam logic       STRAP_4LINE = 1'b0;

    // =====================================================================
    // receive state
    // =====================================================================
    typedef enum logic [1:0] {
        LINK_IDLE  = 2'b00,
        LINK_SHIFT = 2'b01,
        LINK_READ  = 2'b10
    } link_state_e;
endpackage

// ### host_model.sv
/*
 * host microcontroller model: select, serial clock, data and qualifier.
 * assumes one task at a time; serial clock 400 ns period in shift, 500 ns in read8, parked low.
 */
`timescale 1ns/1ps
module host_model (
    output logic      sel_n,
    output logic      sclk,
    output logic      sdata_in,
    output logic      dc_sel,
    input  wire logic sdata_out,
    input  wire logic sdata_oe,
    input  wire logic busy
);
    logic line_seen;

    // a released line reads inverted, so a read outside the drive window cannot pass
    assign line_seen = sdata_oe ? sdata_out : ~sdata_out;
    // =====================================================
    // idle levels
    // =====================================================
    initial begin
        sel_n = 1'b1;
        sclk = 1'b0;
        sdata_in = 1'b0;
        dc_sel = 1'b0;
    end
    // hold off while busy, odd offset keeps phase unrelated to mclk
    task automatic open_frame();
        while (busy === 1'b1) #50;
        #13 sel_n = 1'b0;
        #200;
    endtask
    // msb first on rising edges, qualifier steady all word
    task automatic shift(input int n, input logic [8:0] w, input logic dc);
        dc_sel = dc;
        for (int i = n - 1; i >= 0; i--) begin
            sdata_in = w[i];
            #200 sclk = 1'b1;
            #200 sclk = 1'b0;
        end
        sdata_in = ~sdata_in; // no stale bit left on the line
    endtask
    // sample late in the low phase: the device's sync adds latency
    task automatic read8(output logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            #300 b[i] = line_seen;
            sclk = 1'b1;
            #200 sclk = 1'b0;
        end
    endtask
    task automatic close_frame();
        #200 sel_n = 1'b1;
        dc_sel = ~dc_sel;
        #400;
    endtask
endmodule

// ### tb_top.sv
/*
 * self-checking bench for the display host serial port.
 * assumes host_model drives the link; 50 ns mclk, 8-cycle reset.
 */
`timescale 1ns/1ps
module tb_top;
    import epd_port_pkg::*;
    logic       mclk, rst, reset_n_input, bus_width_strap, waveform_active;
    logic       sensor_active, read_request, sel_n, sclk, sdata_in, dc_sel;
    logic       sdata_out, sdata_oe, read_byte_take, rx_is_data, rx_valid;
    logic       three_line_mode, busy;
    logic [7:0] read_byte, rx_byte, rd;
    logic [8:0] got_word;
    int         err_total, n_compared, n_words, n_takes, cycles;

    epaper_serial_host_port uut (.mclk(mclk), .rst(rst), .reset_n_input(reset_n_input),
        .bus_width_strap(bus_width_strap), .sel_n(sel_n), .sclk(sclk),
        .sdata_in(sdata_in), .sdata_out(sdata_out), .sdata_oe(sdata_oe), .dc_sel(dc_sel),
        .waveform_active(waveform_active), .sensor_active(sensor_active),
        .read_request(read_request), .read_byte(read_byte),
        .read_byte_take(read_byte_take), .rx_byte(rx_byte), .rx_is_data(rx_is_data),
        .rx_valid(rx_valid), .three_line_mode(three_line_mode), .busy(busy));
    host_model host (.sel_n(sel_n), .sclk(sclk), .sdata_in(sdata_in), .dc_sel(dc_sel),
        .sdata_out(sdata_out), .sdata_oe(sdata_oe), .busy(busy));

    // =====================================================
    // clock, monitor and hang guard
    // =====================================================
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // rx_valid stands one cycle, so it is caught here
    always @(posedge mclk) begin
        if (rx_valid === 1'b1) begin
            got_word <= {rx_is_data, rx_byte};
            n_words <= n_words + 1;
        end
        if (read_byte_take === 1'b1) n_takes <= n_takes + 1;
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            err_total++;
            tally_and_finish();
        end
    end

    task automatic chk(input string what, input logic [8:0] seen, input logic [8:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask
    task automatic word(input int n, input logic [8:0] w, input logic dc);
        host.open_frame();
        host.shift(n, w, dc);
        host.close_frame();
        step(2);
    endtask

    // =====================================================
    // scenarios
    // =====================================================
    task automatic t_four_line();
        word(8, 9'h0A5, 1'b0);
        chk("cmd word", got_word, 9'h0A5);
        word(8, 9'h03C, 1'b1);
        chk("data word", got_word, 9'h13C);
    endtask
    task automatic t_select();
        int n0;
        n0 = n_words;
        host.shift(8, 9'h0FF, 1'b1);
        step(4);
        chk("deselected", 9'(n_words - n0), 9'h000);
        host.open_frame();
        host.shift(5, 9'h01F, 1'b1);
        host.close_frame();
        word(8, 9'h096, 1'b0);
        chk("after abort", got_word, 9'h096);
        chk("word count", 9'(n_words - n0), 9'h001);
    endtask
    task automatic t_three_line();
        bus_width_strap = 1'b1;
        step(6);
        chk("mode 3", {8'h00, three_line_mode}, 9'h001);
        word(9, 9'h15A, 1'b0);
        chk("3 data", got_word, 9'h15A);
        word(9, 9'h0E7, 1'b1);
        chk("3 cmd", got_word, 9'h0E7);
        bus_width_strap = 1'b0;
        step(6);
        chk("mode 4", {8'h00, three_line_mode}, 9'h000);
    endtask
    task automatic t_busy();
        for (int k = 0; k < 2; k++) begin
            {sensor_active, waveform_active} = 2'(k + 1);
            step(3);
            chk("busy on", {8'h00, busy}, 9'h001);
            {sensor_active, waveform_active} = 2'b00;
            step(10);
            chk("busy held", {8'h00, busy}, 9'h001);
            step(20);
            chk("busy off", {8'h00, busy}, 9'h000);
        end
    endtask
    task automatic t_reset_pin();
        waveform_active = 1'b1;
        step(3);
        reset_n_input = 1'b0;
        step(5);
        chk("reset busy", {8'h00, busy}, 9'h000);
        reset_n_input = 1'b1;
        waveform_active = 1'b0;
        step(30);
    endtask
    task automatic t_read();
        int t0;
        t0 = n_takes;
        read_request = 1'b1;
        read_byte = 8'hC3;
        host.open_frame();
        host.shift(8, 9'h00B, 1'b0);
        host.read8(rd);
        step(1);
        read_request = 1'b0;
        chk("read byte", {1'b0, rd}, 9'h0C3);
        chk("oe reading", {8'h00, sdata_oe}, 9'h001);
        host.close_frame();
        step(4);
        chk("oe released", {8'h00, sdata_oe}, 9'h000);
        chk("byte taken", {8'h00, n_takes != t0}, 9'h001);
    endtask

    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        {err_total, n_compared, n_words, n_takes, cycles} = '0;
        {rst, reset_n_input} = 2'b11;
        {bus_width_strap, waveform_active, sensor_active, read_request} = 4'h0;
        read_byte = 8'h00;
        step(8);
        rst = 1'b0;
        step(6);
        t_four_line();
        t_select();
        t_three_line();
        t_busy();
        t_reset_pin();
        t_read();
        tally_and_finish();
    end
endmodule
